// ===== optical_sample_fifo_pkg.sv
package optical_sample_fifo_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_WRITE_INDEX = 8'h04;
	localparam logic [7:0] ADDR_READ_INDEX = 8'h05;
	localparam logic [7:0] ADDR_LOST_TALLY = 8'h06;
	localparam logic [7:0] ADDR_ITEMS_AVAIL = 8'h07;
	localparam logic [7:0] ADDR_POP_PORT = 8'h08;
	localparam logic [7:0] ADDR_WATERMARK_CFG = 8'h09;
	localparam logic [7:0] ADDR_BEHAVIOUR_CFG = 8'h0A;

	// ------------------------------------------------------------
	// Behaviour configuration field positions
	// ------------------------------------------------------------
	localparam int TIME_STAMP_EN_BIT = 5;
	localparam int FLUSH_BIT = 4;
	localparam int CLEAR_ON_POP_BIT = 3;
	localparam int A_FULL_TYPE_BIT = 2;
	localparam int OVERWRITE_BIT = 1;

	// ------------------------------------------------------------
	// Item layout and tags
	// ------------------------------------------------------------
	localparam int TAG_MSB = 23;
	localparam int TAG_LSB = 19;
	localparam int VALUE_MSB = 18;
	localparam int LAST_BIT = 24;
	localparam logic [4:0] TAG_INVALID = 5'h1E;
	localparam logic [4:0] TAG_TIME_STAMP = 5'h1F;
	localparam logic [18:0] VALUE_ZERO = 19'h00000;

	// ------------------------------------------------------------
	// Sizes, limits and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] FIFO_DEPTH = 8'h80;
	localparam logic [6:0] TALLY_MAX = 7'h7F;
	localparam logic [6:0] INDEX_RESET = 7'h00;
	localparam logic [6:0] TALLY_RESET = 7'h00;
	localparam logic [7:0] AVAIL_RESET = 8'h00;
	localparam logic [6:0] WATERMARK_RESET = 7'h00;
	localparam logic [21:0] SAMPLE_CNT_RESET = 22'h000000;
	localparam logic [2:0] TIME_STAMP_PHASE = 3'h0;
	localparam logic [1:0] BYTE_PHASE_FIRST = 2'h0;
	localparam logic [1:0] BYTE_PHASE_MID = 2'h1;
	localparam logic [1:0] BYTE_PHASE_LAST = 2'h2;
	localparam logic [1:0] BUF_ENTRIES = 2'h2;

endpackage

// ===== optical_sample_fifo.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Seven-bit read index names next item; advances once per item read.
// - Host may write the read index to step back and re-read.
// - Read index wraps from 0x7F to 0x00.
// - Lost items counted in a 7-bit tally saturating at 0x7F.
// - Tally returns to zero whenever the read index advances by a pop.
// - Eight-bit available count: up on push, down on each item read.
// - Items are three bytes, burst read; index advances after third byte.
// - Items enter in sequence slot order, each carrying its slot tag.
// - Item holds 5-bit tag in 23:19, 19-bit value in 18:0.
// - Almost-full when stored items reach 128 minus watermark.
// - With enable mask set, almost-full flag is raised and drives pin.
// - Status register read clears the almost-full flag.
// - Full: overwrite bit pushes and drops oldest, else new item dropped.
// - Mode low: flag reasserts on every new sample while condition holds.
// - Mode high: flag set only on a fresh almost-full condition.
// - Clear-on-pop high adds data register reads as a clear source.
// - Flush empties FIFO, zeroes indices, count and tally; self-clears.
// - Time-stamp on: 22-bit counter, push upper 19 bits every 8 samples.
// - Counter steps after a full sample set and on sync commands.
// - Conversion restart by reconfiguration zeroes the sample counter.
// - Time-stamp off: no counter items are ever pushed.
// - Seven-bit write index advances per push, wraps 0x7F to 0x00.
// - Reading an empty FIFO returns an item tagged 11110.
// - Time-stamp items carry tag 11111.
module optical_sample_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic conv_valid,
	output logic conv_ready,
	input wire logic [4:0] conv_tag,
	input wire logic [18:0] conv_value,
	input wire logic conv_last,
	input wire logic sample_sync_pin,
	input wire logic soft_sample_sync,
	input wire logic reconfig_restart,
	input wire logic almost_full_enable,
	input wire logic status_read,
	output logic almost_full_flag,
	output logic data_ready_flag,
	output logic int_out_n
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [127:0][23:0] mem;
		logic [6:0] write_index;
		logic [6:0] read_index;
		logic [6:0] tally;
		logic [7:0] avail;
		logic [6:0] watermark;
		logic ts_en;
		logic clear_on_pop;
		logic a_full_type;
		logic overwrite;
		logic [1:0] byte_phase;
		logic [23:0] out_item;
		logic out_real;
		logic out_lost;
		logic [21:0] sample_cnt;
		logic ts_pending;
		logic cond_prev;
		logic af_flag;
		logic dr_flag;
		logic int_n;
		logic [1:0][24:0] buf_q;
		logic [1:0] buf_cnt;
		logic in_ready;
		logic [7:0] rdata;
		logic [2:0] sync_sr;
	} state_t;

	state_t q;
	state_t next_q;

	logic pop_hit;
	logic cfg2_wr;
	logic flush;
	logic pop;
	logic take;
	logic push;
	logic [23:0] push_item;
	logic full_now;
	logic store;
	logic sync_evt;
	logic sample_done;
	logic [21:0] cnt_inc;
	logic cond;
	logic [7:0] threshold;
	logic af_set;
	logic dr_set;
	logic flag_clear;
	logic accept;
	logic [23:0] first_item;
	logic [1:0] cnt_after_take;
	logic lost_now;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_q = q;

		// Sync pin: two stages, edge found past the second stage
		next_q.sync_sr = {q.sync_sr[1:0], sample_sync_pin};
		sync_evt = (q.sync_sr[1] & ~q.sync_sr[2]) | soft_sample_sync;

		pop_hit = reg_rd
			&& (reg_addr == optical_sample_fifo_pkg::ADDR_POP_PORT);
		cfg2_wr = reg_wr
			&& (reg_addr == optical_sample_fifo_pkg::ADDR_BEHAVIOUR_CFG);
		flush = cfg2_wr && reg_wdata[optical_sample_fifo_pkg::FLUSH_BIT];

		// Item leaves only after its third byte, and only if real
		pop = pop_hit
			&& (q.byte_phase == optical_sample_fifo_pkg::BYTE_PHASE_LAST)
			&& q.out_real && !q.out_lost;

		// Time-stamp takes the write slot, so the buffer stalls meanwhile
		take = (q.buf_cnt != 2'h0) && !q.ts_pending && !flush;
		push = !flush && (take || (q.ts_pending && q.ts_en));
		if (q.ts_pending) begin
			push_item = {optical_sample_fifo_pkg::TAG_TIME_STAMP,
				q.sample_cnt[21:3]};
		end else begin
			push_item = q.buf_q[0][23:0];
		end

		// A pop in the same cycle frees a place first
		full_now = (q.avail == optical_sample_fifo_pkg::FIFO_DEPTH) && !pop;
		store = push && (!full_now || q.overwrite);

		// --------------------------------------------------------
		// Pointer, count and tally
		// --------------------------------------------------------
		if (store) begin
			next_q.mem[q.write_index] = push_item;
			next_q.write_index = q.write_index + 7'h01;
		end
		if (push && full_now) begin
			// Either the oldest or the new item is lost
			if (q.tally != optical_sample_fifo_pkg::TALLY_MAX) begin
				next_q.tally = q.tally + 7'h01;
			end
			if (q.overwrite) begin
				next_q.read_index = q.read_index + 7'h01;
			end
		end
		if (pop) begin
			next_q.read_index = q.read_index + 7'h01;
			next_q.tally = optical_sample_fifo_pkg::TALLY_RESET;
		end
		// Count stays at 128 on overwrite, so it never exceeds depth
		if (store && !full_now && !pop) begin
			next_q.avail = q.avail + 8'h01;
		end else if (pop && !(store && !full_now)) begin
			next_q.avail = q.avail - 8'h01;
		end

		// --------------------------------------------------------
		// Host register writes
		// --------------------------------------------------------
		if (reg_wr) begin
			case (reg_addr)
				optical_sample_fifo_pkg::ADDR_READ_INDEX: begin
					next_q.read_index = reg_wdata[6:0];
				end
				optical_sample_fifo_pkg::ADDR_WATERMARK_CFG: begin
					next_q.watermark = reg_wdata[6:0];
				end
				optical_sample_fifo_pkg::ADDR_BEHAVIOUR_CFG: begin
					next_q.ts_en =
						reg_wdata[optical_sample_fifo_pkg::TIME_STAMP_EN_BIT];
					next_q.clear_on_pop =
						reg_wdata[optical_sample_fifo_pkg::CLEAR_ON_POP_BIT];
					next_q.a_full_type =
						reg_wdata[optical_sample_fifo_pkg::A_FULL_TYPE_BIT];
					next_q.overwrite =
						reg_wdata[optical_sample_fifo_pkg::OVERWRITE_BIT];
				end
				default: begin
				end
			endcase
		end

		// Flush is never stored, so it reads back as zero
		if (flush) begin
			next_q.write_index =
				optical_sample_fifo_pkg::INDEX_RESET;
			next_q.read_index = optical_sample_fifo_pkg::INDEX_RESET;
			next_q.avail = optical_sample_fifo_pkg::AVAIL_RESET;
			next_q.tally = optical_sample_fifo_pkg::TALLY_RESET;
			next_q.ts_pending = 1'b0;
		end

		// --------------------------------------------------------
		// Byte-wise read of the pop port
		// --------------------------------------------------------
		if (q.avail != 8'h00) begin
			first_item = q.mem[q.read_index];
		end else begin
			first_item = {optical_sample_fifo_pkg::TAG_INVALID,
				optical_sample_fifo_pkg::VALUE_ZERO};
		end

		next_q.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				optical_sample_fifo_pkg::ADDR_WRITE_INDEX: begin
					next_q.rdata = {1'b0, q.write_index};
				end
				optical_sample_fifo_pkg::ADDR_READ_INDEX: begin
					next_q.rdata = {1'b0, q.read_index};
				end
				optical_sample_fifo_pkg::ADDR_LOST_TALLY: begin
					next_q.rdata = {1'b0, q.tally};
				end
				optical_sample_fifo_pkg::ADDR_ITEMS_AVAIL: begin
					next_q.rdata = q.avail;
				end
				optical_sample_fifo_pkg::ADDR_WATERMARK_CFG: begin
					next_q.rdata = {1'b0, q.watermark};
				end
				optical_sample_fifo_pkg::ADDR_BEHAVIOUR_CFG: begin
					next_q.rdata = 8'h00;
					next_q.rdata[optical_sample_fifo_pkg::TIME_STAMP_EN_BIT] =
						q.ts_en;
					next_q.rdata[optical_sample_fifo_pkg::CLEAR_ON_POP_BIT] =
						q.clear_on_pop;
					next_q.rdata[optical_sample_fifo_pkg::A_FULL_TYPE_BIT] =
						q.a_full_type;
					next_q.rdata[optical_sample_fifo_pkg::OVERWRITE_BIT] =
						q.overwrite;
				end
				optical_sample_fifo_pkg::ADDR_POP_PORT: begin
					// Item latched on first byte so later pushes cannot tear it
					case (q.byte_phase)
						optical_sample_fifo_pkg::BYTE_PHASE_FIRST: begin
							next_q.out_item = first_item;
							next_q.out_real = (q.avail != 8'h00);
							next_q.out_lost = 1'b0;
							next_q.rdata = first_item[23:16];
							next_q.byte_phase =
								optical_sample_fifo_pkg::BYTE_PHASE_MID;
						end
						optical_sample_fifo_pkg::BYTE_PHASE_MID: begin
							next_q.rdata = q.out_item[15:8];
							next_q.byte_phase =
								optical_sample_fifo_pkg::BYTE_PHASE_LAST;
						end
						default: begin
							next_q.rdata = q.out_item[7:0];
							next_q.byte_phase =
								optical_sample_fifo_pkg::BYTE_PHASE_FIRST;
						end
					endcase
				end
				default: begin
					next_q.rdata = 8'h00;
				end
			endcase
		end
		if (flush) begin
			next_q.byte_phase = optical_sample_fifo_pkg::BYTE_PHASE_FIRST;
		end

		// --------------------------------------------------------
		// Overwrite during a burst read
		// --------------------------------------------------------
		// The overwrite may drop the very item whose bytes are going out;
		// its last byte then must not pop the next, still unread item.
		lost_now = push && full_now && q.overwrite && next_q.out_real
			&& (next_q.byte_phase
				!= optical_sample_fifo_pkg::BYTE_PHASE_FIRST);
		if (lost_now) begin
			next_q.out_lost = 1'b1;
		end else if (flush) begin
			next_q.out_lost = 1'b0;
		end

		// --------------------------------------------------------
		// Sample counter and time-stamp
		// --------------------------------------------------------
		sample_done = take && q.buf_q[0][optical_sample_fifo_pkg::LAST_BIT];
		cnt_inc = q.sample_cnt + 22'h000001;
		if (q.ts_pending && push) begin
			next_q.ts_pending = 1'b0;
		end
		if (reconfig_restart) begin
			next_q.sample_cnt =
				optical_sample_fifo_pkg::SAMPLE_CNT_RESET;
			next_q.ts_pending = 1'b0;
		end else if (sample_done || sync_evt) begin
			next_q.sample_cnt = cnt_inc;
			if (q.ts_en && !flush
				&& (cnt_inc[2:0]
					== optical_sample_fifo_pkg::TIME_STAMP_PHASE)) begin
				next_q.ts_pending = 1'b1;
			end
		end
		if (!next_q.ts_en) begin
			next_q.ts_pending = 1'b0;
		end

		// --------------------------------------------------------
		// Almost-full and data-ready flags
		// --------------------------------------------------------
		threshold = optical_sample_fifo_pkg::FIFO_DEPTH - {1'b0, q.watermark};
		cond = (q.avail >= threshold);
		next_q.cond_prev = cond;
		if (q.a_full_type) begin
			af_set = cond && !q.cond_prev;
		end else begin
			af_set = cond && (!q.cond_prev || store);
		end
		af_set = af_set && almost_full_enable;
		dr_set = sample_done;
		flag_clear = status_read
			|| (q.clear_on_pop && pop_hit);
		// Set wins over a clear in the same cycle
		if (af_set) begin
			next_q.af_flag = 1'b1;
		end else if (flag_clear) begin
			next_q.af_flag = 1'b0;
		end
		if (dr_set) begin
			next_q.dr_flag = 1'b1;
		end else if (flag_clear) begin
			next_q.dr_flag = 1'b0;
		end
		next_q.int_n = !next_q.af_flag;

		// --------------------------------------------------------
		// Two-entry input buffer
		// --------------------------------------------------------
		accept = conv_valid && q.in_ready;
		cnt_after_take = q.buf_cnt;
		if (take) begin
			next_q.buf_q[0] = q.buf_q[1];
			cnt_after_take = q.buf_cnt - 2'h1;
		end
		next_q.buf_cnt = cnt_after_take;
		if (accept) begin
			next_q.buf_q[cnt_after_take[0]] =
				{conv_last, conv_tag, conv_value};
			next_q.buf_cnt = cnt_after_take + 2'h1;
		end
		next_q.in_ready =
			(next_q.buf_cnt < optical_sample_fifo_pkg::BUF_ENTRIES);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.int_n <= 1'b1;
			q.in_ready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata = q.rdata;
	assign conv_ready = q.in_ready;
	assign almost_full_flag = q.af_flag;
	assign data_ready_flag = q.dr_flag;
	assign int_out_n = q.int_n;

endmodule // optical_sample_fifo

// ===== optical_sample_fifo_properties.sv
`timescale 1ns/1ps
module optical_sample_fifo_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic conv_valid,
	input wire logic conv_ready,
	input wire logic [4:0] conv_tag,
	input wire logic [18:0] conv_value,
	input wire logic conv_last,
	input wire logic sample_sync_pin,
	input wire logic soft_sample_sync,
	input wire logic reconfig_restart,
	input wire logic almost_full_enable,
	input wire logic status_read,
	input wire logic almost_full_flag,
	input wire logic data_ready_flag,
	input wire logic int_out_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic pop_rd;
	assign pop_rd = reg_rd
		&& reg_addr == optical_sample_fifo_pkg::ADDR_POP_PORT;
	property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not idle");
	property p_int_pin; int_out_n == !almost_full_flag; endproperty
	a_int_pin: assert property (p_int_pin)
		else $error("pin does not follow flag");
	property p_af_masked;
		!almost_full_enable [*3] ##0 !almost_full_flag |=> !almost_full_flag;
	endproperty
	a_af_masked: assert property (p_af_masked)
		else $error("flag set while masked");
	property p_af_hold;
		almost_full_flag && !status_read && !pop_rd |=> almost_full_flag;
	endproperty
	a_af_hold: assert property (p_af_hold)
		else $error("flag dropped without clear");
	property p_dr_hold;
		data_ready_flag && !status_read && !pop_rd |=> data_ready_flag;
	endproperty
	a_dr_hold: assert property (p_dr_hold)
		else $error("ready flag dropped without clear");
	property p_idx_msb;
		reg_rd && reg_addr == optical_sample_fifo_pkg::ADDR_READ_INDEX
			|=> !reg_rdata[7];
	endproperty
	a_idx_msb: assert property (p_idx_msb)
		else $error("index top bit set");
	property p_tally_msb;
		reg_rd && reg_addr == optical_sample_fifo_pkg::ADDR_LOST_TALLY
			|=> !reg_rdata[7];
	endproperty
	a_tally_msb: assert property (p_tally_msb)
		else $error("tally top bit set");
	property p_avail_max;
		reg_rd && reg_addr == optical_sample_fifo_pkg::ADDR_ITEMS_AVAIL
			|=> reg_rdata <= optical_sample_fifo_pkg::FIFO_DEPTH;
	endproperty
	a_avail_max: assert property (p_avail_max)
		else $error("count above depth");
	property p_cfg_read;
		reg_rd && reg_addr == optical_sample_fifo_pkg::ADDR_BEHAVIOUR_CFG
			|=> reg_rdata[7:6] == 2'h0 && !reg_rdata[4] && !reg_rdata[0];
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("flush or spare bits read back");
	property p_ready_back; !conv_ready |-> ##[1:4] conv_ready; endproperty
	a_ready_back: assert property (p_ready_back)
		else $error("input stalled too long");
	c_af: cover property ($rose(almost_full_flag));
	c_dr: cover property ($rose(data_ready_flag));
	c_clr: cover property (status_read ##1 !almost_full_flag);
endmodule // optical_sample_fifo_properties

bind optical_sample_fifo optical_sample_fifo_properties u_props (.*);

// ===== optical_host_model.sv
`timescale 1ns/1ps
module optical_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	output logic status_read
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		status_read = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task clr;
		@(posedge clk);
		status_read <= 1'b1;
		@(posedge clk);
		status_read <= 1'b0;
	endtask
	// Whole item, high byte first
	task get(output logic [23:0] it);
		rd(optical_sample_fifo_pkg::ADDR_POP_PORT, it[23:16]);
		rd(optical_sample_fifo_pkg::ADDR_POP_PORT, it[15:8]);
		rd(optical_sample_fifo_pkg::ADDR_POP_PORT, it[7:0]);
	endtask
	// Tally before count, as a draining host must
	task sizeup(output logic [7:0] t, output logic [7:0] n);
		rd(optical_sample_fifo_pkg::ADDR_LOST_TALLY, t);
		rd(optical_sample_fifo_pkg::ADDR_ITEMS_AVAIL, n);
	endtask
endmodule // optical_host_model

// ===== optical_sample_fifo_tb_top.sv
`timescale 1ns/1ps
module optical_sample_fifo_tb_top;
	logic clk = 0, rst_n = 0, reg_wr, reg_rd, status_read, conv_ready;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic conv_valid = 0, conv_last = 0, sample_sync_pin = 0;
	logic soft_sample_sync = 0, reconfig_restart = 0, almost_full_enable = 0;
	logic [4:0] conv_tag = 0;
	logic [18:0] conv_value = 0;
	logic almost_full_flag, data_ready_flag, int_out_n;
	int err_total = 0, check_count = 0, wri, rdi, cnt, tally, scnt, i;
	logic [23:0] mem [128];
	logic [23:0] it;
	logic [7:0] b, t;
	bit ow, ts;
	optical_sample_fifo uut (.*);
	optical_host_model host (.*);
	always #2 clk = ~clk;
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	function void put(input logic [23:0] x);
		if (cnt == 128) begin
			tally = (tally < 127) ? tally + 1 : 127;
			if (!ow) return;
			rdi = (rdi + 1) % 128;
			cnt--;
		end
		mem[wri] = x;
		wri = (wri + 1) % 128;
		cnt++;
	endfunction
	task push(input bit l);
		it = {5'(1 + $urandom % 6), 19'($urandom)};
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_tag <= it[23:19];
		conv_value <= it[18:0];
		conv_last <= l;
		do @(posedge clk); while (conv_ready !== 1'b1);
		conv_valid <= 1'b0;
		put(it);
		if (l) scnt++;
		if (l && ts && scnt % 8 == 0) put({5'h1F, 19'(scnt / 8)});
	endtask
	task fill(input int n);
		for (i = 0; i < n; i++) push(i == n - 1);
		repeat (6) @(posedge clk);
	endtask
	task get_chk;
		host.get(it);
		if (cnt == 0) chk("empty item", 24'hF00000, it);
		else begin
			chk("item", mem[rdi], it);
			rdi = (rdi + 1) % 128;
			cnt--;
			tally = 0;
		end
	endtask
	task regs;
		host.rd(optical_sample_fifo_pkg::ADDR_WRITE_INDEX, b);
		chk("write index", 24'(wri), 24'(b));
		host.rd(optical_sample_fifo_pkg::ADDR_READ_INDEX, b);
		chk("read index", 24'(rdi), 24'(b));
		host.sizeup(t, b);
		chk("tally", 24'(tally), 24'(t));
		chk("count", 24'(cnt), 24'(b));
	endtask
	task cfg(input logic [7:0] v);
		host.wr(optical_sample_fifo_pkg::ADDR_BEHAVIOUR_CFG, v);
		ow = v[1];
		ts = v[5];
		if (v[4]) begin
			wri = 0;
			rdi = 0;
			cnt = 0;
			tally = 0;
		end
		repeat (3) @(posedge clk);
	endtask
	task flag(input logic e);
		repeat (4) @(posedge clk);
		#1;
		chk("almost full", 24'(e), 24'(almost_full_flag));
		chk("pin", 24'(!e), 24'(int_out_n));
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(92360));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		regs;
		host.rd(8'h40, b);
		chk("unmapped", 24'h0, 24'(b));
		$display("test 1 done");
		fill(5);
		regs;
		repeat (6) get_chk;
		regs;
		$display("test 2 done");
		fill(2);
		get_chk;
		rdi = rdi - 1;
		host.wr(optical_sample_fifo_pkg::ADDR_READ_INDEX, 8'(rdi));
		get_chk;
		get_chk;
		$display("test 3 done");
		cfg(8'h10);
		fill(130);
		chk("ready", 24'h1, 24'(conv_ready));
		regs;
		get_chk;
		regs;
		$display("test 4 done");
		cfg(8'h12);
		fill(129);
		regs;
		get_chk;
		$display("test 5 done");
		cfg(8'h10);
		host.wr(optical_sample_fifo_pkg::ADDR_WATERMARK_CFG, 8'h04);
		host.clr;
		almost_full_enable <= 1'b1;
		fill(123);
		flag(1'b0);
		fill(1);
		flag(1'b1);
		host.clr;
		flag(1'b0);
		fill(1);
		flag(1'b1);
		cfg(8'h0C);
		host.clr;
		fill(1);
		flag(1'b0);
		chk("data ready", 24'h1, 24'(data_ready_flag));
		get_chk;
		repeat (2) @(posedge clk);
		chk("data ready", 24'h0, 24'(data_ready_flag));
		almost_full_enable <= 1'b0;
		regs;
		$display("test 6 done");
		cfg(8'h30);
		regs;
		@(posedge clk) reconfig_restart <= 1'b1;
		@(posedge clk) reconfig_restart <= 1'b0;
		@(posedge clk) soft_sample_sync <= 1'b1;
		@(posedge clk) soft_sample_sync <= 1'b0;
		sample_sync_pin <= 1'b1;
		repeat (2) @(posedge clk);
		sample_sync_pin <= 1'b0;
		repeat (4) @(posedge clk);
		scnt = 2;
		repeat (6) fill(1);
		regs;
		repeat (8) get_chk;
		$display("test 7 done");
		report_and_stop;
	end
	initial begin
		#100000;
		err_total++;
		report_and_stop;
	end
endmodule // optical_sample_fifo_tb_top
